// ---- design/ldd_rx_end.sv ----
// Deserializing receiver end: recovers the parallel word and the pixel clock
//
// How it works
// - Sample seven evenly spaced bits per link period
// - Four data lanes share one link clock
// - Present 28-bit word every link period
// - Pixel clock out; data captured on falling edge
// - Pixel clock period bounded by link clock rate
// - Sleep input low forces all outputs low
// - Outputs reach low within one microsecond of sleep
// - Lock to link clock; outputs invalid until locked
// - Word field mapping agreed between both ends
// - Reduced variant: three lanes, 21-bit word
module ldd_rx_end
  import ldd_pkg::*;
#(
  parameter int LANES        = LDD_LANES_FULL,
  parameter int LOCK_MATCHES = LDD_LOCK_MATCHES
) (
  input  wire logic                       core_clk,
  input  wire logic                       reset_n,
  ldd_link_if.rx                          link,
  input  wire logic                       sleep_n,
  output logic [LDD_SLOTS*LANES-1:0]      parallel_word_out,
  output logic                            pixel_clock_out,
  output logic                            link_locked
);

  localparam int WORD_W = LDD_SLOTS * LANES;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Clock and lanes pass the same two stages, so the lane sample taken in
  // a given cycle lines up with the clock edge seen in that cycle
  logic             lclk_s1_q;
  logic             lclk_s2_q;
  logic             lclk_s3_q;
  logic [LANES-1:0] lane_s1_q;
  logic [LANES-1:0] lane_s2_q;
  logic             sleep_s1_q;
  logic             sleep_s2_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lclk_s1_q  <= 1'b0;
      lclk_s2_q  <= 1'b0;
      lclk_s3_q  <= 1'b0;
      lane_s1_q  <= '0;
      lane_s2_q  <= '0;
      sleep_s1_q <= 1'b0;
      sleep_s2_q <= 1'b0;
    end else begin
      lclk_s1_q  <= link.link_clock_in;
      lclk_s2_q  <= lclk_s1_q;
      lclk_s3_q  <= lclk_s2_q;
      lane_s1_q  <= link.serial_lane_in;
      lane_s2_q  <= lane_s1_q;
      sleep_s1_q <= sleep_n;
      sleep_s2_q <= sleep_s1_q;
    end
  end

  // ****************************************************************
  // Period tracking and slot sampling state
  // ****************************************************************
  ldd_rx_state_type        state_q, state_d;
  logic [LDD_CNT_W-1:0]    cnt_q, cnt_d;
  logic [LDD_CNT_W-1:0]    period_q, period_d;
  logic [LDD_MATCH_W-1:0]  match_q, match_d;
  logic [LDD_THR_W-1:0]    thr_q, thr_d;
  logic [LDD_SLOT_W-1:0]   slot_q, slot_d;
  logic [WORD_W-1:0]       samp_q, samp_d;
  logic [WORD_W-1:0]       word_q, word_d;
  logic                    pclk_q, pclk_d;
  logic [LDD_CNT_W-1:0]    hi_q, hi_d;
  logic                    locked_q, locked_d;

  logic                    rise;
  logic                    hit;
  logic [LDD_THR_W-1:0]    phase;

  // Two period measurements agree when they differ by at most one cycle,
  // which absorbs the sampling jitter of an asynchronous link clock
  function automatic logic near(input logic [LDD_CNT_W-1:0] a, input logic [LDD_CNT_W-1:0] b);
    logic [LDD_CNT_W-1:0] diff;
    diff = (a > b) ? (a - b) : (b - a);
    return diff <= LDD_CNT_W'(1);
  endfunction

  // Slot k is taken once 14*c reaches (2k+1)*P - 7. The synchronised sample
  // trails the pin by up to a cycle, so aiming half a cycle before the centre
  // keeps slot 6 ahead of the next rise when the period is short
  assign rise  = lclk_s2_q & ~lclk_s3_q;
  assign phase = LDD_THR_W'(cnt_q) * LDD_SLOT_STEP;
  assign hit   = (slot_q < LDD_SLOT_W'(LDD_SLOTS)) && (phase >= thr_q);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d  = state_q;
    cnt_d    = (cnt_q == LDD_CNT_MAX) ? cnt_q : cnt_q + 1'b1;
    period_d = period_q;
    match_d  = match_q;
    thr_d    = thr_q;
    slot_d   = slot_q;
    samp_d   = samp_q;
    word_d   = word_q;
    pclk_d   = pclk_q;
    hi_d     = hi_q;
    locked_d = locked_q;

    // Pixel clock stays high for half the measured period plus one cycle
    if (pclk_q) begin
      if (hi_q == '0) begin
        pclk_d = 1'b0;
      end else begin
        hi_d = hi_q - 1'b1;
      end
    end

    case (state_q)
      LDD_RX_SLEEP: begin
        word_d   = '0;
        pclk_d   = 1'b0;
        locked_d = 1'b0;
        match_d  = '0;
        slot_d   = LDD_SLOT_W'(LDD_SLOTS);
        if (sleep_s2_q) begin
          state_d = LDD_RX_HUNT;
        end
      end
      LDD_RX_HUNT, LDD_RX_TRACK: begin
        if (!sleep_s2_q) begin
          state_d  = LDD_RX_SLEEP;
          word_d   = '0;
          pclk_d   = 1'b0;
          locked_d = 1'b0;
        end else if (rise) begin
          period_d = cnt_q;
          cnt_d    = LDD_CNT_W'(1);
          thr_d    = (cnt_q > LDD_CNT_W'(LDD_SLOTS)) ? LDD_THR_W'(cnt_q) - LDD_THR_W'(LDD_SLOTS) : '0;
          slot_d   = '0;
          if (near(cnt_q, period_q)) begin
            match_d = (match_q == '1) ? match_q : match_q + 1'b1;
            if (state_q == LDD_RX_HUNT && int'(match_q) + 1 >= LOCK_MATCHES) begin
              state_d  = LDD_RX_TRACK;
              locked_d = 1'b1;
            end
          end else begin
            match_d = '0;
            if (state_q == LDD_RX_TRACK) begin
              state_d  = LDD_RX_HUNT;
              locked_d = 1'b0;
              word_d   = '0;
              pclk_d   = 1'b0;
            end
          end
        end else if (cnt_q == LDD_CNT_MAX) begin
          // Link clock stopped: drop lock until a steady clock returns
          state_d  = LDD_RX_HUNT;
          locked_d = 1'b0;
          match_d  = '0;
          slot_d   = LDD_SLOT_W'(LDD_SLOTS);
          word_d   = '0;
          pclk_d   = 1'b0;
        end else if (hit) begin
          for (int l = 0; l < LANES; l++) begin
            samp_d[l*LDD_SLOTS + int'(slot_q)] = lane_s2_q[l];
          end
          slot_d = slot_q + 1'b1;
          thr_d  = thr_q + LDD_THR_W'({period_q, 1'b0});
          if (slot_q == LDD_SLOT_W'(LDD_SLOTS - 1) && state_q == LDD_RX_TRACK) begin
            word_d = samp_d;
            pclk_d = 1'b1;
            hi_d   = period_q >> 1;
          end
        end
      end
      default: begin
        state_d  = LDD_RX_SLEEP;
        word_d   = '0;
        pclk_d   = 1'b0;
        locked_d = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q  <= LDD_RX_SLEEP;
      cnt_q    <= '0;
      period_q <= '0;
      match_q  <= '0;
      thr_q    <= '0;
      slot_q   <= LDD_SLOT_W'(LDD_SLOTS);
      samp_q   <= '0;
      word_q   <= '0;
      pclk_q   <= 1'b0;
      hi_q     <= '0;
      locked_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      period_q <= period_d;
      match_q  <= match_d;
      thr_q    <= thr_d;
      slot_q   <= slot_d;
      samp_q   <= samp_d;
      word_q   <= word_d;
      pclk_q   <= pclk_d;
      hi_q     <= hi_d;
      locked_q <= locked_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // While locked, the word changes only with the pixel clock's rising edge, so it is stable
  // for a full period around the falling edge the consumer strobes on
  assign parallel_word_out = word_q;
  assign pixel_clock_out   = pclk_q;
  assign link_locked       = locked_q;

endmodule

// ---- design/ldd_pkg.sv ----
// Shared constants for the serial display link receiver and its transmitter
package ldd_pkg;

  // ****************************************************************
  // Link geometry
  // ****************************************************************
  localparam int LDD_LANES_FULL    = 4;
  localparam int LDD_LANES_REDUCED = 3;
  localparam int LDD_SLOTS         = 7;
  localparam int LDD_SLOT_W        = 3;

  // ****************************************************************
  // Transmitter bit timing: bit length in core clock cycles, link clock high time in slots
  // ****************************************************************
  localparam int LDD_BIT_CYCLES     = 4;
  localparam int LDD_BIT_W          = 3;
  localparam int LDD_CLK_HIGH_SLOTS = 4;

  // ****************************************************************
  // Receiver period tracking
  // ****************************************************************
  localparam int                LDD_CNT_W       = 8;
  localparam int                LDD_THR_W       = 12;
  localparam int                LDD_MATCH_W     = 4;
  localparam logic [11:0]       LDD_SLOT_STEP   = 12'h00E;
  localparam logic [7:0]        LDD_CNT_MAX     = 8'hFF;
  localparam int                LDD_LOCK_MATCHES = 4;

  // ****************************************************************
  // Timing figures
  // ****************************************************************
  localparam int LDD_CORE_CLK_HZ   = 40000000;
  localparam int LDD_SLEEP_DELAY_NS = 1000;
  localparam int LDD_SLEEP_DELAY_CYC = (LDD_SLEEP_DELAY_NS * (LDD_CORE_CLK_HZ / 1000000)) / 1000;
  localparam int LDD_LOCK_TIME_MS  = 10;
  localparam int LDD_LOCK_TIME_CYC = LDD_LOCK_TIME_MS * (LDD_CORE_CLK_HZ / 1000);

  // ****************************************************************
  // Recommended word layout, full width variant
  // ****************************************************************
  localparam int LDD_RED_LSB   = 0;
  localparam int LDD_GREEN_LSB = 8;
  localparam int LDD_BLUE_LSB  = 16;
  localparam int LDD_LINE_POS  = 24;
  localparam int LDD_FRAME_POS = 25;
  localparam int LDD_VALID_POS = 26;
  localparam int LDD_SPARE_POS = 27;

  // ****************************************************************
  // Recommended word layout, reduced variant
  // ****************************************************************
  localparam int LDD_R_RED_LSB   = 0;
  localparam int LDD_R_GREEN_LSB = 6;
  localparam int LDD_R_BLUE_LSB  = 12;
  localparam int LDD_R_LINE_POS  = 18;
  localparam int LDD_R_FRAME_POS = 19;
  localparam int LDD_R_VALID_POS = 20;

  // ****************************************************************
  // States
  // ****************************************************************
  typedef enum logic [2:0] {
    LDD_RX_SLEEP = 3'b001,
    LDD_RX_HUNT  = 3'b010,
    LDD_RX_TRACK = 3'b100
  } ldd_rx_state_type;

  typedef enum logic [1:0] {
    LDD_TX_IDLE = 2'b01,
    LDD_TX_SEND = 2'b10
  } ldd_tx_state_type;

endpackage

// ---- design/ldd_link_if.sv ----
// Serial link wires between transmitter and receiver
interface ldd_link_if #(
  parameter int LANES = 4
);
  logic             link_clock_in;
  logic [LANES-1:0] serial_lane_in;

  modport tx (
    output link_clock_in,
    output serial_lane_in
  );

  modport rx (
    input link_clock_in,
    input serial_lane_in
  );
endinterface

// ---- design/ldd_tx_end.sv ----
// Serializing transmitter end: drives seven bits per lane per link clock period
module ldd_tx_end
  import ldd_pkg::*;
#(
  parameter int LANES = LDD_LANES_FULL
) (
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  ldd_link_if.tx                        link,
  input  wire logic                     tx_enable,
  input  wire logic [LDD_SLOTS*LANES-1:0] word_in,
  output logic                          word_taken
);

  localparam int WORD_W = LDD_SLOTS * LANES;

  ldd_tx_state_type        state_q, state_d;
  logic [LDD_BIT_W-1:0]    bit_q, bit_d;
  logic [LDD_SLOT_W-1:0]   slot_q, slot_d;
  logic [WORD_W-1:0]       shift_q, shift_d;
  logic                    lclk_q, lclk_d;
  logic [LANES-1:0]        lane_q, lane_d;
  logic                    taken_q, taken_d;

  // Picks one slot of every lane out of a word; lane l slot k sits at l*7+k
  function automatic logic [LANES-1:0] slot_bits(input logic [WORD_W-1:0] w, input int k);
    logic [LANES-1:0] r;
    r = '0;
    for (int l = 0; l < LANES; l++) begin
      r[l] = w[l*LDD_SLOTS + k];
    end
    return r;
  endfunction

  // ****************************************************************
  // Slot sequencing and link clock divider
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    bit_d   = bit_q;
    slot_d  = slot_q;
    shift_d = shift_q;
    lclk_d  = lclk_q;
    lane_d  = lane_q;
    taken_d = 1'b0;
    case (state_q)
      LDD_TX_IDLE: begin
        lclk_d = 1'b0;
        lane_d = '0;
        if (tx_enable) begin
          state_d = LDD_TX_SEND;
          shift_d = word_in;
          taken_d = 1'b1;
          bit_d   = '0;
          slot_d  = '0;
          lclk_d  = 1'b1;
          lane_d  = slot_bits(word_in, 0);
        end
      end
      LDD_TX_SEND: begin
        if (bit_q == LDD_BIT_W'(LDD_BIT_CYCLES - 1)) begin
          bit_d = '0;
          if (slot_q == LDD_SLOT_W'(LDD_SLOTS - 1)) begin
            if (tx_enable) begin
              shift_d = word_in;
              taken_d = 1'b1;
              slot_d  = '0;
              lclk_d  = 1'b1;
              lane_d  = slot_bits(word_in, 0);
            end else begin
              state_d = LDD_TX_IDLE;
              lclk_d  = 1'b0;
              lane_d  = '0;
            end
          end else begin
            slot_d = slot_q + 1'b1;
            lclk_d = (int'(slot_q) + 1) < LDD_CLK_HIGH_SLOTS;
            lane_d = slot_bits(shift_q, int'(slot_q) + 1);
          end
        end else begin
          bit_d = bit_q + 1'b1;
        end
      end
      default: begin
        state_d = LDD_TX_IDLE;
        lclk_d  = 1'b0;
        lane_d  = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= LDD_TX_IDLE;
      bit_q   <= '0;
      slot_q  <= '0;
      shift_q <= '0;
      lclk_q  <= 1'b0;
      lane_q  <= '0;
      taken_q <= 1'b0;
    end else begin
      state_q <= state_d;
      bit_q   <= bit_d;
      slot_q  <= slot_d;
      shift_q <= shift_d;
      lclk_q  <= lclk_d;
      lane_q  <= lane_d;
      taken_q <= taken_d;
    end
  end

  assign link.link_clock_in  = lclk_q;
  assign link.serial_lane_in = lane_q;
  assign word_taken          = taken_q;

endmodule

// ---- bench/ldd_link_props.sv ----
// Concurrent checks on the serial link and on the receiver outputs
module ldd_link_props
  import ldd_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        link_clock_in,
  input wire logic [3:0]  serial_lane_in,
  input wire logic        tx_enable,
  input wire logic        word_taken,
  input wire logic        sleep_n,
  input wire logic [27:0] parallel_word_out,
  input wire logic        pixel_clock_out,
  input wire logic        link_locked
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Cycles since the transmitter was disabled
  // ****
  logic [5:0] idle_q;
  logic [5:0] idle_d;
  always_comb begin
    idle_d = tx_enable ? 6'h00 : ((idle_q == 6'h3F) ? idle_q : idle_q + 6'h01);
  end
  always_ff @(posedge core_clk) begin
    idle_q <= reset_n ? idle_d : 6'h00;
  end
  default clocking
    @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // ****
  // Assertions
  // ****
  sleep_low_a: assert property (
    !sleep_n [*5] |-> parallel_word_out == 28'h0000000 && !pixel_clock_out && !link_locked)
    else $error("outputs not low while asleep");
  sleep_delay_a: assert property (
    $fell(sleep_n) |-> ##[1:40] (parallel_word_out == 28'h0000000 && !pixel_clock_out))
    else $error("sleep not reached in time");
  unlocked_quiet_a: assert property (
    !link_locked && !$past(link_locked) |-> parallel_word_out == 28'h0000000 && !pixel_clock_out)
    else $error("output while unlocked");
  word_strobe_a: assert property (
    link_locked && $past(link_locked) && $changed(parallel_word_out) |-> $rose(pixel_clock_out))
    else $error("word changed without strobe");
  strobe_width_a: assert property (
    $rose(pixel_clock_out) |-> ##14 (pixel_clock_out || !link_locked) ##1 !pixel_clock_out)
    else $error("pixel clock high time wrong");
  word_period_a: assert property (
    $rose(pixel_clock_out) |-> ##28 ($rose(pixel_clock_out) || !link_locked || !tx_enable))
    else $error("word period wrong");
  taken_period_a: assert property (
    word_taken && tx_enable |=> !word_taken ##27 (word_taken || !tx_enable))
    else $error("word taken spacing wrong");
  link_clock_a: assert property (
    word_taken |-> link_clock_in ##16 !link_clock_in)
    else $error("link clock shape wrong");
  clock_start_a: assert property (
    $rose(link_clock_in) |-> word_taken)
    else $error("link clock rose without word");
  idle_low_a: assert property (
    idle_q >= 6'h20 |-> !link_clock_in && serial_lane_in == 4'h0)
    else $error("idle link not low");
  cover property ($rose(link_locked));
  cover property ($fell(sleep_n));
  cover property ($rose(pixel_clock_out) && link_locked);
endmodule

// ---- bench/tb_lvds_display_deserializer.sv ----
// Testbench: transmitter and receiver back to back, plus a receiver fed by a faulty bench driver
module tb_lvds_display_deserializer
  import ldd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk  = 1'b0;
  logic        reset_n   = 1'b0;
  logic        tx_enable = 1'b0;
  logic        sleep_n   = 1'b1;
  logic [27:0] word_in   = 28'h0000000;
  logic        word_taken;
  logic [27:0] rx_word;
  logic [27:0] f_word;
  logic        rx_pclk;
  logic        rx_locked;
  logic        f_locked;
  logic [27:0] got [$];
  int          err_total = 0;
  int          compares  = 0;
  logic        r_enable  = 1'b0;
  logic [20:0] r_word_in = 21'h000000;
  logic [20:0] r_word;
  logic        r_locked;
  ldd_link_if link ();
  ldd_link_if flink ();
  ldd_link_if #(.LANES(3)) rlink ();
  initial begin
    flink.link_clock_in = 1'b0;
    flink.serial_lane_in = 4'h0;
  end
  ldd_tx_end ldd_tx_end_i (.core_clk(core_clk), .reset_n(reset_n), .link(link),
    .tx_enable(tx_enable), .word_in(word_in), .word_taken(word_taken));
  ldd_rx_end ldd_rx_end_i (.core_clk(core_clk), .reset_n(reset_n),
    .link(link), .sleep_n(sleep_n), .parallel_word_out(rx_word), .pixel_clock_out(rx_pclk),
    .link_locked(rx_locked));
  ldd_rx_end fault_ldd_rx_end_i (.core_clk(core_clk),
    .reset_n(reset_n), .link(flink), .sleep_n(1'b1), .parallel_word_out(f_word),
    .pixel_clock_out(), .link_locked(f_locked));
  // Reduced variant pair
  ldd_tx_end #(.LANES(3)) red_ldd_tx_end_i (.core_clk(core_clk), .reset_n(reset_n), .link(rlink),
    .tx_enable(r_enable), .word_in(r_word_in), .word_taken());
  ldd_rx_end #(.LANES(3)) red_ldd_rx_end_i (.core_clk(core_clk), .reset_n(reset_n), .link(rlink),
    .sleep_n(sleep_n), .parallel_word_out(r_word), .pixel_clock_out(), .link_locked(r_locked));
  ldd_link_props ldd_link_props_i (.core_clk(core_clk), .reset_n(reset_n),
    .link_clock_in(link.link_clock_in), .serial_lane_in(link.serial_lane_in),
    .tx_enable(tx_enable), .word_taken(word_taken), .sleep_n(sleep_n),
    .parallel_word_out(rx_word), .pixel_clock_out(rx_pclk), .link_locked(rx_locked));
  initial forever #12.5 core_clk = ~core_clk;
  // Downstream capture on the strobe's falling edge
  always @(negedge rx_pclk) if (rx_locked === 1'b1) got.push_back(rx_word);
  // ****
  // Helpers
  // ****
  task automatic chk_word(input string what, input logic [27:0] exp, input logic [27:0] seen);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    chk_word(what, {27'h0, exp}, {27'h0, seen});
  endtask
  function automatic logic [27:0] pat(input int n);
    if (n < 8) return 28'hC3C3C30 + 28'(n);
    if (n < 36) return 28'h0000001 << (n - 8);
    return (n == 36) ? 28'hFFFFFFF : ((n == 37) ? 28'hAAAAAAA : 28'h5555555);
  endfunction
  function automatic logic [3:0] lanes(input logic [27:0] w, input int k);
    return {w[21+k], w[14+k], w[7+k], w[k]};
  endfunction
  task automatic conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_lock(input int lim);
    int w;
    for (w = 0; w < lim && rx_locked !== 1'b1; w++) @(negedge core_clk);
  endtask
  task automatic frame(input real slot, input logic [3:0] v);
    for (int k = 0; k < 7; k++) begin
      flink.link_clock_in = (k < 4);
      flink.serial_lane_in = v;
      #(slot);
    end
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_stream;
    int w;
    int j;
    word_in = pat(0);
    tx_enable = 1'b1;
    for (int n = 0; n < 39; n++) begin
      for (w = 0; w < 40 && word_taken !== 1'b1; w++) @(negedge core_clk);
      chk_bit("word_taken", 1'b1, word_taken);
      if (n == 38) tx_enable = 1'b0;
      else word_in = pat(n + 1);
      for (int k = 0; k < 7; k++) begin
        chk_word("lanes", {24'h0, lanes(pat(n), k)}, {24'h0, link.serial_lane_in});
        chk_bit("link clock", k < 4, link.link_clock_in);
        repeat (4) @(negedge core_clk);
      end
    end
    repeat (340) @(negedge core_clk);
    chk_bit("lock dropped", 1'b0, rx_locked);
    for (j = 0; j < 8 && got.size() > 0 && pat(j) !== got[0]; j++);
    chk_word("word count", 28'(39 - j), 28'(got.size()));
    foreach (got[i]) chk_word("rx word", pat(j + i), got[i]);
  endtask
  task automatic t_sleep;
    word_in = 28'h1234567;
    tx_enable = 1'b1;
    wait_lock(400);
    repeat (60) @(negedge core_clk);
    chk_word("awake word", 28'h1234567, rx_word);
    sleep_n = 1'b0;
    repeat (40) @(negedge core_clk);
    chk_word("sleep word", 28'h0000000, rx_word);
    chk_bit("sleep clock", 1'b0, rx_pclk);
    sleep_n = 1'b1;
    wait_lock(400);
    chk_bit("relock", 1'b1, rx_locked);
    tx_enable = 1'b0;
  endtask
  task automatic t_fault;
    #7;
    repeat (10) frame(200.0 / 7.0, 4'hF);
    repeat (5) frame(200.0 / 7.0, 4'h5);
    chk_bit("fault locked", 1'b1, f_locked);
    chk_word("fault word", 28'h01FC07F, f_word);
    frame(300.0 / 7.0, 4'h5);
    frame(200.0 / 7.0, 4'h5);
    flink.link_clock_in = 1'b0;
    flink.serial_lane_in = 4'hA;
    repeat (20) @(negedge core_clk);
    chk_bit("fault unlock", 1'b0, f_locked);
    chk_word("fault quiet", 28'h0000000, f_word);
  endtask
  task automatic t_reduced;
    r_word_in = 21'h15A5C3;
    r_enable = 1'b1;
    for (int w = 0; w < 400 && r_locked !== 1'b1; w++) @(negedge core_clk);
    repeat (60) @(negedge core_clk);
    chk_bit("reduced lock", 1'b1, r_locked);
    chk_word("reduced word", {7'h00, 21'h15A5C3}, {7'h00, r_word});
    r_enable = 1'b0;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
    t_stream();
    t_sleep();
    t_fault();
    t_reduced();
    conclude();
  end
  initial begin
    #100us;
    err_total++;
    conclude();
  end
endmodule
